//--- swdp_pkg.sv
// Register map, field layout and timing constants of the debug port registers
package swdp_pkg;
  // Offsets: physical bank 0x0-0x3, access bank 0x7-0xC
  localparam logic [3:0] OFF_REV_STATUS   = 4'h0;
  localparam logic [3:0] OFF_ERR_STATUS   = 4'h1;
  localparam logic [3:0] OFF_LINK_CTRL_A  = 4'h2;
  localparam logic [3:0] OFF_LINK_CTRL_B  = 4'h3;
  localparam logic [3:0] OFF_PHY_LAST     = 4'h3;
  localparam logic [3:0] OFF_KEY_STATUS   = 4'h7;
  localparam logic [3:0] OFF_RESET_REQ    = 4'h8;
  localparam logic [3:0] OFF_CLK_SELECT   = 4'h9;
  localparam logic [3:0] OFF_SYS_CTRL_A   = 4'hA;
  localparam logic [3:0] OFF_SYS_STATUS   = 4'hB;
  localparam logic [3:0] OFF_SCAN_STATUS  = 4'hC;
  localparam logic [3:0] OFF_ACC_LAST     = 4'hC;
  // Revision value is arbitrary
  localparam logic [3:0] PORT_REVISION    = 4'h2;
  // Link control A fields
  localparam int CA_INTER_BYTE_DELAY_EN   = 7;
  localparam int CA_PARITY_DISABLE    = 5;
  localparam int CA_DTD     = 4;
  localparam int CA_RSD     = 3;
  localparam logic [7:0] CA_WMASK = 8'hBF;
  localparam logic [7:0] CA_RESET = 8'h00;
  // Link control B fields
  localparam int CB_NACKDIS = 4;
  localparam int CB_CCDIS   = 3;
  localparam int CB_DIS     = 2;
  // System control A / status fields
  localparam int SC_SYSTEM_CLOCK_REQUEST  = 0;
  localparam int SC_UFINAL  = 1;
  localparam logic [7:0] SC_RESET = 8'h01;
  localparam int SS_RSTSYS  = 5;
  localparam int SS_ASLEEP  = 4;
  localparam int SS_NVMPROG = 3;
  localparam int SS_UROW    = 2;
  localparam int SS_LOCK    = 0;
  localparam logic [1:0] CLK_SEL_RESET = 2'h3;
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;
  // Error signatures
  localparam logic [2:0] ERR_NONE    = 3'h0;
  localparam logic [2:0] ERR_PARITY  = 3'h1;
  localparam logic [2:0] ERR_FRAME   = 3'h2;
  localparam logic [2:0] ERR_TIMEOUT = 3'h3;
  localparam logic [2:0] ERR_CLKREC  = 3'h4;
  localparam logic [2:0] ERR_CONTEND = 3'h7;
  // Timing, in port clock cycles
  localparam int TIMEOUT_CYCLES  = 65536;
  localparam int IDLE_CHAR_BITS  = 12;
  localparam int IB_GAP_CHARS    = 2;
  localparam int IB_GAP_BITS     = IB_GAP_CHARS * IDLE_CHAR_BITS;
  localparam logic [2:0] GT_OFF  = 3'h7;
  localparam int GUARD_MAX_CYC   = 128;
  typedef enum logic [1:0] {SWDP_TX_IDLE, SWDP_TX_GAP, SWDP_TX_SEND}
    swdp_tx_state_t;
endpackage

//--- swdp_gap_if.sv
// Handshake between the register block and the transmit gap timer
`timescale 1ns/1ps
`default_nettype none
interface swdp_gap_if;
  logic       start;
  logic       first;
  logic       ib_en;
  logic [2:0] gt_sel;
  logic       done;
  modport ctrl  (output start, output first, output ib_en, output gt_sel,
                 input done);
  modport timer (input start, input first, input ib_en, input gt_sel,
                 output done);
endinterface
`default_nettype wire

//--- swdp_gap_timer.sv
// Idle-bit gap timer placed before each transmitted byte
`timescale 1ns/1ps
`default_nettype none
module swdp_gap_timer
  import swdp_pkg::*;
(
  // Clock and reset
  input wire logic   ref_clk,
  input wire logic   rst,
  input wire logic   clr,
  // Control side
  swdp_gap_if.timer  gap
);
  typedef struct packed {
    logic       busy;
    logic [7:0] cnt;
  } swdp_gt_st_t;
  swdp_gt_st_t s_q, s_d;

  // Guard count halves with each select step
  function automatic logic [7:0] guard_len(input logic [2:0] sel);
    guard_len = 8'(GUARD_MAX_CYC >> sel);
  endfunction

  always_comb begin
    s_d = s_q;
    gap.done = 1'b0;
    if (clr) begin
      s_d = '0;
    end else if (!s_q.busy) begin
      if (gap.start) begin
        if (!gap.first && gap.ib_en) begin
          s_d.busy = 1'b1;
          s_d.cnt  = 8'(IB_GAP_BITS - 1);
        end else if (gap.first && gap.gt_sel != GT_OFF) begin
          s_d.busy = 1'b1;
          s_d.cnt  = guard_len(gap.gt_sel) - 8'h01;
        end else begin
          gap.done = 1'b1;
        end
      end
    end else if (s_q.cnt == 8'h00) begin
      s_d.busy = 1'b0;
      gap.done = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

//--- swdp_regs.sv
// Control and status registers of the single-wire debug port
// Behaviour
// - System-asleep bit follows idle-or-deeper sleep of system domain
// - Clock request bit set keeps system clock running through sleep
// - Clock request bit resets to one
// - Registers reachable only over the debug link, never by processor
// - Offsets 0x0-0x3 physical bank, 0x7-0xC access bank
// - Read-only revision in bits 7:4 of first status register
// - Error signature loaded on port error, cleared on debugger read
// - Error codes: parity 1, frame 2, clock recovery 4, contention 7
// - Code 3 when access layer gives no response
// - Inter-byte delay enable inserts two idle characters between bytes
// - First byte of multi-byte transmit uses guard time instead
// - Parity disable ignores parity bit and its error
// - Time-out after 65536 cycles unless detection disabled
// - Response signature disable suppresses all response signatures
// - Guard select 0..6 gives 128 halving to 2 cycles, 7 off
// - Writing 0x59 asserts system reset, other values release; bit0 reads
// - Port disable drops clock request and resets configuration and error signature
`timescale 1ns/1ps
`default_nettype none
module swdp_regs
  import swdp_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Register access from the link instruction decoder
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // Physical layer events
  input  wire logic       phy_parity_err,
  input  wire logic       phy_frame_err,
  input  wire logic       phy_clkrec_err,
  input  wire logic       phy_contention,
  input  wire logic       tx_byte_req,
  input  wire logic       tx_first_byte,
  output logic            tx_byte_go,
  output logic            parity_check_en,
  output logic            contention_det_en,
  output logic            response_sig_en,
  // Access layer handshake
  input  wire logic       acc_req,
  input  wire logic       acc_ack,
  // System domain
  input  wire logic       sys_sleeping,
  input  wire logic       sys_in_reset,
  input  wire logic [2:0] key_active,
  input  wire logic       nvm_prog_ready,
  input  wire logic       urow_prog_ready,
  input  wire logic       sys_locked,
  input  wire logic [2:0] scan_status,
  output logic            system_clock_request,
  output logic            system_reset_hold,
  output logic            urow_write_final,
  output logic            port_reset,
  output logic      [1:0] port_clock_select
);
  typedef struct packed {
    logic [7:0]  ctrl_a;
    logic        port_disable;
    logic [2:0]  error_signature;
    logic        reset_hold;
    logic [1:0]  clk_sel;
    logic        clk_req;
    logic        urow_final;
    logic        rst_seen;
    logic        waiting;
    logic [16:0] wait_cnt;
    logic [7:0]  rdata;
    logic        rd_valid;
    swdp_tx_state_t tx_st;
  } swdp_st_t;
  swdp_st_t s_q, s_d;

  swdp_gap_if gap ();

  swdp_gap_timer u_gap (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clr     (s_q.port_disable),
    .gap     (gap.timer)
  );

  // Mapped offsets, with the reserved hole between the two banks
  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a <= OFF_PHY_LAST) ||
                (a >= OFF_KEY_STATUS && a <= OFF_ACC_LAST);
  endfunction

  logic        parity_hit;
  logic        timeout_hit;
  logic [7:0]  rd_mux;

  assign parity_hit  = phy_parity_err && !s_q.ctrl_a[CA_PARITY_DISABLE];
  assign timeout_hit = s_q.waiting && !s_q.ctrl_a[CA_DTD] &&
                       s_q.wait_cnt == 17'(TIMEOUT_CYCLES - 1);

  // Only the debug link reaches this decode; no processor path exists
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      OFF_REV_STATUS:  rd_mux = {PORT_REVISION, 4'h0};
      OFF_ERR_STATUS:  rd_mux = {5'h00, s_q.error_signature};
      OFF_LINK_CTRL_A: rd_mux = s_q.ctrl_a & CA_WMASK;
      OFF_LINK_CTRL_B: rd_mux = 8'h00;
      OFF_KEY_STATUS:  rd_mux = {2'h0, key_active, 3'h0};
      OFF_RESET_REQ:   rd_mux = {7'h00, s_q.reset_hold};
      OFF_CLK_SELECT:  rd_mux = {6'h00, s_q.clk_sel};
      OFF_SYS_CTRL_A:  rd_mux = {6'h00, s_q.urow_final, s_q.clk_req};
      OFF_SYS_STATUS: begin
        rd_mux = 8'h00;
        rd_mux[SS_RSTSYS]  = s_q.rst_seen;
        rd_mux[SS_ASLEEP]  = sys_sleeping;
        rd_mux[SS_NVMPROG] = nvm_prog_ready;
        rd_mux[SS_UROW]    = urow_prog_ready;
        rd_mux[SS_LOCK]    = sys_locked;
      end
      OFF_SCAN_STATUS: rd_mux = {5'h00, scan_status};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.rd_valid = reg_rd;
    if (reg_rd) begin
      s_d.rdata = is_mapped(reg_addr) ? rd_mux : 8'h00;
    end
    gap.start  = 1'b0;
    gap.first  = tx_first_byte;
    gap.ib_en  = s_q.ctrl_a[CA_INTER_BYTE_DELAY_EN];
    gap.gt_sel = s_q.ctrl_a[2:0];
    tx_byte_go = 1'b0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_LINK_CTRL_A: s_d.ctrl_a = reg_wdata & CA_WMASK;
        OFF_LINK_CTRL_B: s_d.port_disable = reg_wdata[CB_DIS];
        OFF_RESET_REQ:
          s_d.reset_hold = (reg_wdata == RESET_SIGNATURE);
        OFF_CLK_SELECT: s_d.clk_sel = reg_wdata[1:0];
        OFF_SYS_CTRL_A: begin
          s_d.clk_req = reg_wdata[SC_SYSTEM_CLOCK_REQUEST];
          if (key_active[2]) begin
            s_d.urow_final = reg_wdata[SC_UFINAL];
          end
        end
        default: ;
      endcase
    end

    // Read-to-clear; a new event in the same cycle survives
    if (reg_rd && reg_addr == OFF_ERR_STATUS) begin
      s_d.error_signature = ERR_NONE;
    end
    if (reg_rd && reg_addr == OFF_SYS_STATUS) begin
      s_d.rst_seen = 1'b0;
    end
    if (sys_in_reset || s_q.reset_hold) begin
      s_d.rst_seen = 1'b1;
    end

    // Access layer wait counter
    if (acc_ack) begin
      s_d.waiting  = 1'b0;
      s_d.wait_cnt = '0;
    end else if (acc_req && !s_q.waiting) begin
      s_d.waiting  = 1'b1;
      s_d.wait_cnt = '0;
    end else if (s_q.waiting) begin
      s_d.wait_cnt = s_q.wait_cnt + 17'h00001;
      if (timeout_hit) begin
        s_d.waiting = 1'b0;
      end
    end

    // Error capture, most severe code wins
    if (phy_contention) begin
      s_d.error_signature = ERR_CONTEND;
    end else if (phy_clkrec_err) begin
      s_d.error_signature = ERR_CLKREC;
    end else if (timeout_hit) begin
      s_d.error_signature = ERR_TIMEOUT;
    end else if (phy_frame_err) begin
      s_d.error_signature = ERR_FRAME;
    end else if (parity_hit) begin
      s_d.error_signature = ERR_PARITY;
    end

    // Transmit pacing
    case (s_q.tx_st)
      SWDP_TX_IDLE: begin
        if (tx_byte_req) begin
          gap.start = 1'b1;
          if (gap.done) begin
            tx_byte_go = 1'b1;
          end else begin
            s_d.tx_st = SWDP_TX_GAP;
          end
        end
      end
      SWDP_TX_GAP: begin
        if (gap.done) begin
          tx_byte_go = 1'b1;
          s_d.tx_st = SWDP_TX_IDLE;
        end
      end
      default: s_d.tx_st = SWDP_TX_IDLE;
    endcase

    // Disabling wipes configuration, error signature and clock request
    if (s_q.port_disable) begin
      s_d.ctrl_a          = CA_RESET;
      s_d.clk_req         = 1'b0;
      s_d.clk_sel         = CLK_SEL_RESET;
      s_d.urow_final      = 1'b0;
      s_d.error_signature = ERR_NONE;
      s_d.waiting         = 1'b0;
      s_d.tx_st           = SWDP_TX_IDLE;
      if (reg_wr && reg_addr == OFF_LINK_CTRL_B) begin
        s_d.port_disable = reg_wdata[CB_DIS];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q            <= '0;
      s_q.ctrl_a     <= CA_RESET;
      s_q.clk_req    <= SC_RESET[SC_SYSTEM_CLOCK_REQUEST];
      s_q.clk_sel    <= CLK_SEL_RESET;
      s_q.tx_st      <= SWDP_TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata            = s_q.rdata;
  assign reg_rd_valid         = s_q.rd_valid;
  assign parity_check_en      = !s_q.ctrl_a[CA_PARITY_DISABLE];
  assign contention_det_en    = 1'b1;
  assign response_sig_en      = !s_q.ctrl_a[CA_RSD];
  assign system_clock_request = s_q.clk_req;
  assign system_reset_hold    = s_q.reset_hold;
  assign urow_write_final     = s_q.urow_final;
  assign port_reset           = s_q.port_disable;
  assign port_clock_select    = s_q.clk_sel;
endmodule
`default_nettype wire

//--- swdp_phy_model.sv
// Transmit-side physical layer model that asks for byte slots
`timescale 1ns/1ps
`default_nettype none
module swdp_phy_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Bench control
  input  wire logic send,
  input  wire logic first,
  output logic      busy,
  output int        lat,
  // Byte handshake
  input  wire logic tx_byte_go,
  output logic      tx_byte_req,
  output logic      tx_first_byte
);
  assign busy = tx_byte_req;
  // Request held until granted, then the qualifier flips so no stale level
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_byte_req <= 1'b0;
      tx_first_byte <= 1'b0;
      lat <= 0;
    end else if (tx_byte_req) begin
      if (tx_byte_go) begin
        tx_byte_req <= 1'b0;
        tx_first_byte <= ~tx_first_byte;
      end else begin
        lat <= lat + 1;
      end
    end else if (send) begin
      tx_byte_req <= 1'b1;
      tx_first_byte <= first;
      lat <= 0;
    end
  end
endmodule
`default_nettype wire

//--- swdp_regs_monitor.sv
// Concurrent checks on the debug port register block
`timescale 1ns/1ps
`default_nettype none
module swdp_regs_monitor
  import swdp_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Register access
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Transmit and link controls
  input wire logic       tx_byte_req,
  input wire logic       tx_first_byte,
  input wire logic       tx_byte_go,
  input wire logic       parity_check_en,
  input wire logic       response_sig_en,
  // System side
  input wire logic       sys_sleeping,
  input wire logic       system_clock_request,
  input wire logic       system_reset_hold,
  input wire logic       port_reset
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_asleep;
    reg_rd && reg_addr == OFF_SYS_STATUS && $stable(sys_sleeping)
      |=> reg_rdata[SS_ASLEEP] == $past(sys_sleeping);
  endproperty
  a_asleep:
    assert property (p_asleep) else $error("sleep bit wrong");
  property p_system_clock_request;
    reg_wr && reg_addr == OFF_SYS_CTRL_A && !port_reset
      |=> system_clock_request == $past(reg_wdata[SC_SYSTEM_CLOCK_REQUEST]);
  endproperty
  a_system_clock_request:
    assert property (p_system_clock_request) else $error("clock request wrong");
  property p_parity_disable;
    reg_wr && reg_addr == OFF_LINK_CTRL_A && !port_reset
      |=> parity_check_en == !$past(reg_wdata[CA_PARITY_DISABLE]);
  endproperty
  a_parity_disable:
    assert property (p_parity_disable) else $error("parity enable wrong");
  property p_rsd;
    reg_wr && reg_addr == OFF_LINK_CTRL_A && !port_reset
      |=> response_sig_en == !$past(reg_wdata[CA_RSD]);
  endproperty
  a_rsd:
    assert property (p_rsd) else $error("signature enable wrong");
  property p_reset_request_code;
    reg_wr && reg_addr == OFF_RESET_REQ
      |=> system_reset_hold == ($past(reg_wdata) == RESET_SIGNATURE);
  endproperty
  a_reset_request_code:
    assert property (p_reset_request_code) else $error("reset hold wrong");
  property p_ibgap;
    $rose(tx_byte_req) && !tx_first_byte && !tx_byte_go
      |=> !tx_byte_go [*8];
  endproperty
  a_ibgap:
    assert property (p_ibgap) else $error("inter-byte gap short");
  property p_gobound;
    tx_byte_req |-> ##[0:131] tx_byte_go;
  endproperty
  a_gobound:
    assert property (p_gobound) else $error("byte grant late");
  property p_drop;
    port_reset |=> !system_clock_request;
  endproperty
  a_drop:
    assert property (p_drop) else $error("clock request kept");
endmodule
bind swdp_regs swdp_regs_monitor swdp_regs_monitor_inst (.*);
`default_nettype wire

//--- tb.sv
// Self-checking bench for the debug port register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import swdp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] ev = 4'h0;
  logic       acc_req = 1'b0;
  logic       acc_ack = 1'b0;
  logic       sys_sleeping = 1'b0;
  logic [2:0] key_active = 3'h0;
  logic [2:0] scan_status = 3'h0;
  logic [2:0] sys_lvl = 3'h0;
  logic       send = 1'b0;
  logic       first = 1'b0;
  logic [7:0] reg_rdata, d;
  logic       reg_rd_valid, tx_byte_req, tx_first_byte, tx_byte_go, busy;
  logic       parity_check_en, response_sig_en, system_clock_request;
  logic       system_reset_hold, port_reset, urow_write_final;
  logic       contention_det_en;
  logic [1:0] port_clock_select;
  int         lat, s;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         codes[$] = '{1, 2, 4, 7};
  swdp_regs swdp_regs_inst (.*, .phy_parity_err(ev[0]),
    .phy_frame_err(ev[1]), .phy_clkrec_err(ev[2]), .phy_contention(ev[3]),
    .sys_in_reset(1'b0), .nvm_prog_ready(sys_lvl[2]),
    .urow_prog_ready(sys_lvl[1]), .sys_locked(sys_lvl[0]));
  swdp_phy_model swdp_phy_model_inst (.*);
  always #4 ref_clk = ~ref_clk;
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("rd_valid", {7'h0, reg_rd_valid}, 8'h01);
    chk("rdata", reg_rdata & m, e & m);
  endtask
  task automatic pulse_ev(int i);
    @(posedge ref_clk);
    ev <= 4'(1 << i);
    @(posedge ref_clk);
    ev <= 4'h0;
  endtask
  task automatic tx(logic f, int lo);
    @(posedge ref_clk);
    send <= 1'b1;
    first <= f;
    @(posedge ref_clk);
    send <= 1'b0;
    #1;
    for (int i = 0; i < 300 && busy; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (busy) begin
      n_fail++;
      end_of_test();
    end else begin
      chk("tx_gap", {7'h0, lat >= lo && lat <= lo + 2}, 8'h01);
    end
  endtask
  initial begin
    s = $urandom(32'he21a9506);
    key_active <= 3'($urandom);
    scan_status <= 3'($urandom);
    sys_lvl <= 3'($urandom);
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFF_REV_STATUS, {PORT_REVISION, 4'h0});
    rd(OFF_ERR_STATUS, 8'h00);
    rd(OFF_LINK_CTRL_A, CA_RESET);
    rd(OFF_SYS_CTRL_A, 8'h01);
    rd(OFF_KEY_STATUS, {2'h0, key_active, 3'h0});
    rd(OFF_SCAN_STATUS, {5'h0, scan_status});
    for (int a = 4; a < 16; a++)
      if (a < 7 || a > 12) rd(4'(a), 8'h00);
    rd(OFF_CLK_SELECT, {6'h0, CLK_SEL_RESET});
    chk("cont_en", {7'h0, contention_det_en}, 8'h01);
    chk("clk_sel", {6'h0, port_clock_select}, {6'h0, CLK_SEL_RESET});
    $display("test reset_values done");
    d = 8'($urandom);
    wr(OFF_LINK_CTRL_A, d);
    rd(OFF_LINK_CTRL_A, d & CA_WMASK);
    chk("parity_en", {7'h0, parity_check_en}, {7'h0, ~d[CA_PARITY_DISABLE]});
    chk("resp_en", {7'h0, response_sig_en}, {7'h0, ~d[CA_RSD]});
    wr(OFF_REV_STATUS, 8'hFF);
    rd(OFF_REV_STATUS, {PORT_REVISION, 4'h0});
    wr(OFF_LINK_CTRL_A, 8'h00);
    foreach (codes[i]) begin
      pulse_ev(i);
      rd(OFF_ERR_STATUS, 8'(codes[i]));
      rd(OFF_ERR_STATUS, 8'h00);
    end
    wr(OFF_LINK_CTRL_A, 8'h20);
    pulse_ev(0);
    rd(OFF_ERR_STATUS, 8'h00);
    $display("test errors done");
    wr(OFF_RESET_REQ, RESET_SIGNATURE);
    rd(OFF_RESET_REQ, 8'h01);
    chk("rst_hold", {7'h0, system_reset_hold}, 8'h01);
    rd(OFF_SYS_STATUS, 8'h20, 8'h20);
    wr(OFF_RESET_REQ, RESET_SIGNATURE ^ 8'(1 + $urandom % 255));
    rd(OFF_RESET_REQ, 8'h00);
    wr(OFF_SYS_CTRL_A, 8'h00);
    chk("clk_req", {7'h0, system_clock_request}, 8'h00);
    wr(OFF_SYS_CTRL_A, 8'h03);
    chk("clk_req", {7'h0, system_clock_request}, 8'h01);
    rd(OFF_SYS_CTRL_A, {6'h0, key_active[2], 1'b1});
    chk("urow", {7'h0, urow_write_final}, {7'h0, key_active[2]});
    // Clock select 0 is reserved, so only 1..3 are written
    d = (8'($urandom) & 8'hFC) | 8'(1 + $urandom % 3);
    wr(OFF_CLK_SELECT, d);
    rd(OFF_CLK_SELECT, {6'h0, d[1:0]});
    chk("clk_sel", {6'h0, port_clock_select}, {6'h0, d[1:0]});
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      sys_sleeping <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      rd(OFF_SYS_STATUS, {3'h0, sys_sleeping, sys_lvl[2:1], 1'b0,
         sys_lvl[0]}, 8'h1D);
    end
    $display("test system_control done");
    for (int g = 0; g < 8; g++) begin
      wr(OFF_LINK_CTRL_A, 8'(g));
      tx(1'b1, g == 7 ? 0 : 128 >> g);
    end
    wr(OFF_LINK_CTRL_A, 8'h87);
    tx(1'b1, 0);
    tx(1'b0, IB_GAP_BITS);
    wr(OFF_LINK_CTRL_A, 8'h07);
    tx(1'b0, 0);
    $display("test transmit_gap done");
    // Error signature stays clear while the access layer answers slowly but within the time-out
    wr(OFF_LINK_CTRL_A, 8'h00);
    @(posedge ref_clk);
    acc_req <= 1'b1;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    repeat (20000) @(posedge ref_clk);
    acc_ack <= 1'b1;
    @(posedge ref_clk);
    acc_ack <= 1'b0;
    acc_req <= 1'b1;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    // First request alone would have timed out by now; the answer restarts it
    repeat (TIMEOUT_CYCLES - 20000) @(posedge ref_clk);
    rd(OFF_ERR_STATUS, 8'h00);
    repeat (20000 - 6) @(posedge ref_clk);
    rd(OFF_ERR_STATUS, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(OFF_ERR_STATUS, {5'h0, ERR_TIMEOUT});
    $display("test timeout done");
    wr(OFF_LINK_CTRL_A, 8'h2A);
    wr(OFF_LINK_CTRL_B, 8'h04);
    @(posedge ref_clk);
    #1;
    chk("port_rst", {7'h0, port_reset}, 8'h01);
    chk("clk_req", {7'h0, system_clock_request}, 8'h00);
    chk("clk_sel", {6'h0, port_clock_select}, {6'h0, CLK_SEL_RESET});
    wr(OFF_LINK_CTRL_B, 8'h00);
    rd(OFF_LINK_CTRL_A, 8'h00);
    rd(OFF_SYS_CTRL_A, 8'h00);
    rd(OFF_LINK_CTRL_B, 8'h00);
    $display("test port_disable done");
    end_of_test();
  end
endmodule
`default_nettype wire
